/* verilog/wwd_pkg.sv */
// constants shared by the window watchdog files
// assumes nothing beyond a single 200 MHz clock domain
package wwd_pkg;
   localparam int        WWD_CNT_W        = 7;
   localparam int        WWD_RUN_BIT      = 7;
   localparam int        WWD_CNT_MSB      = 6;
   localparam int        WWD_CFG_W        = 10;
   localparam int        WWD_CFG_IRQ_BIT  = 9;
   localparam int        WWD_CFG_SEL_LSB  = 7;
   localparam int        WWD_CFG_SEL_MSB  = 8;
   localparam int        WWD_CFG_WIN_MSB  = 6;
   localparam int        WWD_STAT_FLAG    = 0;
   localparam logic [7:0] WWD_CTRL_RESET  = 8'h7f;
   localparam logic [9:0] WWD_CFG_RESET   = 10'h07f;
   localparam logic [6:0] WWD_CNT_EXPIRE  = 7'h3f;
   localparam logic [6:0] WWD_CNT_WARN    = 7'h40;
   localparam int        WWD_BASE_DIV     = 4096;
   localparam int        WWD_SEL_W        = 2;
   localparam int        WWD_DIV_W        = 15;
endpackage

/* verilog/wwd_tick_div.sv */
// tick divider: one-cycle tick every BASE_DIV * 2**sel clock cycles
// assumes enable and restart are synchronous to clk
`timescale 1ns/1ps
module wwd_tick_div
   import wwd_pkg::*;
#(
   parameter int BASE_DIV = WWD_BASE_DIV
) (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 enable,
   input  wire logic                 restart,
   input  wire logic [WWD_SEL_W-1:0] divSel,
   output logic                      tick
);
   logic [WWD_DIV_W-1:0] cnt_q;
   logic [WWD_DIV_W-1:0] term;

   if (BASE_DIV < 1 || BASE_DIV > WWD_BASE_DIV) begin : g_chk
      $error("BASE_DIV out of range");
   end

   // terminal count of the selected power-of-two stage
   assign term = WWD_DIV_W'((BASE_DIV << divSel) - 1);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (restart || !enable) begin
         cnt_q <= '0;
      end else if (cnt_q == term) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= enable && !restart && (cnt_q == term);
      end
   end
endmodule

/* verilog/wwd_window_watchdog.sv */
// window watchdog: 7-bit down-counter, window check, early warning
// assumes register writes arrive as one-cycle strobes; reset request goes to reset control
`timescale 1ns/1ps
module wwd_window_watchdog
   import wwd_pkg::*;
#(
   parameter int BASE_DIV = WWD_BASE_DIV
) (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 ctrlWrEn,
   input  wire logic [7:0]           ctrlWrData,
   input  wire logic                 cfgWrEn,
   input  wire logic [WWD_CFG_W-1:0] cfgWrData,
   input  wire logic                 statWrEn,
   input  wire logic                 statWrData,
   input  wire logic                 debugHalt,
   input  wire logic                 debugHaltFreeze,
   output logic [7:0]                ctrlRd,
   output logic [WWD_CFG_W-1:0]      cfgRd,
   output logic                      earlyWarnFlag,
   output logic                      earlyWarnInterrupt,
   output logic                      resetReq
);
   logic                 run_q;
   logic [WWD_CNT_W-1:0] count_q;
   logic [WWD_CNT_W-1:0] window_q;
   logic [WWD_SEL_W-1:0] divSel_q;
   logic                 irqEn_q;
   logic                 flag_q;
   logic                 irq_q;
   logic                 resetReq_q;
   logic                 tick;
   logic                 frozen;
   logic                 stepOk;
   logic                 refresh;
   logic                 premature;
   logic                 expire;
   logic                 warn;

   assign frozen    = debugHalt && debugHaltFreeze;
   assign stepOk    = run_q && !frozen && !resetReq_q;
   assign refresh   = ctrlWrEn && run_q && !resetReq_q;
   assign premature = refresh && (count_q > window_q);
   assign expire    = stepOk && tick && !ctrlWrEn && (count_q == WWD_CNT_WARN);
   assign warn      = stepOk && tick && !ctrlWrEn
                      && (count_q == WWD_CNT_WARN + 7'h01);

   wwd_tick_div #(
      .BASE_DIV (BASE_DIV)
   ) u_tick (
      .clk     (clk),
      .arst_n  (arst_n),
      .enable  (stepOk),
      .restart (refresh || resetReq_q),
      .divSel  (divSel_q),
      .tick    (tick)
   );

   // run-enable and counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         run_q   <= WWD_CTRL_RESET[WWD_RUN_BIT];
         count_q <= WWD_CTRL_RESET[WWD_CNT_W-1:0];
      end else if (resetReq_q) begin
         run_q   <= WWD_CTRL_RESET[WWD_RUN_BIT];
         count_q <= WWD_CTRL_RESET[WWD_CNT_W-1:0];
      end else if (ctrlWrEn) begin
         run_q   <= run_q || ctrlWrData[WWD_RUN_BIT];
         count_q <= ctrlWrData[WWD_CNT_W-1:0];
      end else if (stepOk && tick) begin
         count_q <= count_q - 7'h01;
      end
   end

   // configuration
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         window_q <= WWD_CFG_RESET[WWD_CFG_WIN_MSB:0];
         divSel_q <= WWD_CFG_RESET[WWD_CFG_SEL_MSB:WWD_CFG_SEL_LSB];
         irqEn_q  <= WWD_CFG_RESET[WWD_CFG_IRQ_BIT];
      end else if (resetReq_q) begin
         window_q <= WWD_CFG_RESET[WWD_CFG_WIN_MSB:0];
         divSel_q <= WWD_CFG_RESET[WWD_CFG_SEL_MSB:WWD_CFG_SEL_LSB];
         irqEn_q  <= WWD_CFG_RESET[WWD_CFG_IRQ_BIT];
      end else if (cfgWrEn) begin
         window_q <= cfgWrData[WWD_CFG_WIN_MSB:0];
         divSel_q <= cfgWrData[WWD_CFG_SEL_MSB:WWD_CFG_SEL_LSB];
         irqEn_q  <= irqEn_q || cfgWrData[WWD_CFG_IRQ_BIT];
      end
   end

   // early-warning flag: set wins over clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (resetReq_q) begin
         flag_q <= 1'b0;
      end else if (warn) begin
         flag_q <= 1'b1;
      end else if (statWrEn && !statWrData) begin
         flag_q <= 1'b0;
      end
   end

   // interrupt and reset request pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q      <= 1'b0;
         resetReq_q <= 1'b0;
      end else begin
         irq_q      <= irqEn_q && (warn || premature);
         resetReq_q <= expire || premature;
      end
   end

   assign ctrlRd             = {run_q, count_q};
   assign cfgRd              = {irqEn_q, divSel_q, window_q};
   assign earlyWarnFlag      = flag_q;
   assign earlyWarnInterrupt = irq_q;
   assign resetReq           = resetReq_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_expire_reset_req: assert property (
      run_q && !frozen && !resetReq_q && tick && !ctrlWrEn && count_q == 7'h40
      |=> resetReq && ctrlRd[6:0] == 7'h3f)
      else $error("no reset request on expiry");

   a_premature_reset_req: assert property (
      ctrlWrEn && run_q && !resetReq_q && count_q > window_q |=> resetReq)
      else $error("no reset request on early refresh");

   a_window_timely_ok: assert property (
      ctrlWrEn && run_q && !resetReq_q && count_q <= window_q && count_q != 7'h40
      |=> !resetReq)
      else $error("reset request on timely refresh");

   a_warn_flag_set: assert property (
      run_q && !frozen && !resetReq_q && tick && !ctrlWrEn && count_q == 7'h41
      |=> earlyWarnFlag && (earlyWarnInterrupt == $past(irqEn_q)))
      else $error("early warning flag or interrupt wrong");

   a_irq_needs_enable: assert property (
      earlyWarnInterrupt |-> $past(irqEn_q) && $past(run_q))
      else $error("interrupt without enable");

   a_disabled_no_reset: assert property (
      !run_q |=> !resetReq)
      else $error("reset request while disabled");

   a_run_sticky_bit: assert property (
      run_q && !resetReq_q |=> run_q)
      else $error("run enable dropped");

   a_flag_clear_write: assert property (
      statWrEn && !statWrData && !warn && !resetReq_q |=> !earlyWarnFlag)
      else $error("flag not cleared");

   a_debug_freeze_hold: assert property (
      debugHalt && debugHaltFreeze && !ctrlWrEn && !resetReq_q |=> $stable(count_q))
      else $error("counter moved while frozen");

   a_reset_pulse_clear: assert property (
      resetReq |=> !resetReq && ctrlRd == 8'h7f && cfgRd == 10'h07f && !earlyWarnFlag)
      else $error("state not restored after reset request");

   a_premature_irq_pulse: assert property (
      ctrlWrEn && run_q && !resetReq_q && count_q > window_q && irqEn_q
      |=> earlyWarnInterrupt)
      else $error("no interrupt on early refresh");

   a_irq_off_disabled: assert property (
      !irqEn_q |=> !earlyWarnInterrupt)
      else $error("interrupt while its enable is clear");

   a_flag_write_one: assert property (
      statWrEn && statWrData && earlyWarnFlag && !resetReq_q |=> earlyWarnFlag)
      else $error("flag cleared by writing one");

   a_run_start_write: assert property (
      ctrlWrEn && ctrlWrData[WWD_RUN_BIT] && !resetReq_q |=> ctrlRd[WWD_RUN_BIT])
      else $error("run enable not set by write");

   a_count_load_write: assert property (
      ctrlWrEn && !resetReq_q |=> ctrlRd[WWD_CNT_W-1:0] == 7'($past(ctrlWrData)))
      else $error("counter not loaded by write");

   a_count_step_tick: assert property (
      !ctrlWrEn && !resetReq_q && !(stepOk && tick) |=> $stable(count_q))
      else $error("counter moved without a tick");

   a_count_step_down: assert property (
      stepOk && tick && !ctrlWrEn && count_q > 7'h40
      |=> count_q == $past(count_q) - 7'h01)
      else $error("counter did not step down by one");

   a_cfg_hold_idle: assert property (
      !cfgWrEn && !resetReq_q |=> $stable(cfgRd))
      else $error("configuration changed without a write");

   a_window_load_write: assert property (
      cfgWrEn && !resetReq_q |=> window_q == 7'($past(cfgWrData)))
      else $error("window not loaded by write");
endmodule

/* tb/wwd_reset_ctrl_model.sv */
// reset controller model: counts reset requests from the watchdog
// assumes resetReq is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
module wwd_reset_ctrl_model (
   input  wire logic clk,
   input  wire logic resetReq,
   output int        resetCount
);
   initial resetCount = 0;
   always @(posedge clk) begin
      if (resetReq === 1'b1) resetCount <= resetCount + 1;
   end
endmodule

/* tb/wwd_window_watchdog_bench.sv */
// testbench for the window watchdog
// assumes a 200 MHz clock and a shortened base divider
`timescale 1ns/1ps
module wwd_window_watchdog_bench
   import wwd_pkg::*;
;
   localparam int DIV = 4;
   logic clk = 1'b0, arst_n = 1'b0, ctrlWrEn = 1'b0, cfgWrEn = 1'b0, statWrEn = 1'b0;
   logic statWrData = 1'b0, debugHalt = 1'b0, debugHaltFreeze = 1'b0;
   logic [7:0] ctrlWrData = 8'h00, ctrlRd;
   logic [WWD_CFG_W-1:0] cfgWrData = 10'h000, cfgRd;
   logic earlyWarnFlag, earlyWarnInterrupt, resetReq;
   int miscompares = 0, cmp_count = 0, cyc = 0, t0, resetCount;
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   wwd_window_watchdog #(.BASE_DIV(DIV)) i_wwd_window_watchdog (.clk, .arst_n, .ctrlWrEn,
      .ctrlWrData, .cfgWrEn, .cfgWrData, .statWrEn, .statWrData, .debugHalt,
      .debugHaltFreeze, .ctrlRd, .cfgRd, .earlyWarnFlag, .earlyWarnInterrupt, .resetReq);
   wwd_reset_ctrl_model i_wwd_reset_ctrl_model (.clk, .resetReq, .resetCount);
   task conclude;
      if (miscompares == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // sel 0 control, 1 configuration, 2 status
   task wr(input int sel, input logic [9:0] d);
      @(posedge clk);
      ctrlWrEn <= (sel == 0);
      cfgWrEn <= (sel == 1);
      statWrEn <= (sel == 2);
      ctrlWrData <= d[7:0];
      cfgWrData <= d;
      statWrData <= d[0];
      @(posedge clk);
      ctrlWrEn <= 1'b0;
      cfgWrEn <= 1'b0;
      statWrEn <= 1'b0;
   endtask
   // which 0 waits for the flag, 1 for the reset request
   task waitSig(input int which);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (((which == 0) ? earlyWarnFlag : resetReq) !== 1'b1 && n < 300);
      if (n >= 300) begin
         miscompares++;
         conclude();
      end
   endtask
   task chkIdle;
      chk("ctrl", 10'h07f, {2'b00, ctrlRd});
      chk("cfg", 10'h07f, cfgRd);
      chk("flag", 10'h000, {9'h0, earlyWarnFlag});
   endtask
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (20) @(negedge clk);
      chkIdle;
      chk("resets", 10'h000, 10'(resetCount));
      // early warning with interrupt, refresh inside window, expiry
      wr(1, 10'h27f);
      wr(0, 10'h0c1);
      wr(0, 10'h041);
      @(negedge clk);
      chk("ctrl", 10'h0c1, {2'b00, ctrlRd});
      waitSig(0);
      t0 = cyc;
      chk("irq", 10'h001, {9'h0, earlyWarnInterrupt});
      chk("ctrl", 10'h0c0, {2'b00, ctrlRd});
      waitSig(1);
      chk("period", 10'(DIV), 10'(cyc - t0));
      chk("cnt", 10'h03f, {3'h0, ctrlRd[6:0]});
      @(negedge clk);
      chkIdle;
      chk("resets", 10'h001, 10'(resetCount));
      // flag without interrupt, slowest divider, clearing the flag
      wr(1, 10'h1ff);
      wr(0, 10'h0c1);
      waitSig(0);
      t0 = cyc;
      chk("irq", 10'h000, {9'h0, earlyWarnInterrupt});
      wr(2, 10'h001);
      @(negedge clk);
      chk("flag", 10'h001, {9'h0, earlyWarnFlag});
      wr(2, 10'h000);
      @(negedge clk);
      chk("flag", 10'h000, {9'h0, earlyWarnFlag});
      waitSig(1);
      chk("period", 10'(DIV * 8), 10'(cyc - t0));
      // refresh above the window
      wr(1, 10'h250);
      wr(0, 10'h0ff);
      wr(0, 10'h0c1);
      @(negedge clk);
      chk("rst", 10'h001, {9'h0, resetReq});
      chk("irq", 10'h001, {9'h0, earlyWarnInterrupt});
      @(negedge clk);
      chkIdle;
      // debug halt with and without freeze
      @(posedge clk);
      debugHalt <= 1'b1;
      debugHaltFreeze <= 1'b1;
      wr(0, 10'h0c5);
      repeat (20) @(negedge clk);
      chk("ctrl", 10'h0c5, {2'b00, ctrlRd});
      @(posedge clk);
      debugHaltFreeze <= 1'b0;
      repeat (7) @(negedge clk);
      chk("ctrl", 10'h0c4, {2'b00, ctrlRd});
      chk("resets", 10'h003, 10'(resetCount));
      conclude();
   end
endmodule
